//--- verilog/itc_consts.svh
// Shared constants of the transfer controller pair.
// Assumes inclusion by bare name; definitions only.
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH
`define ITC_NSRC      32
`define ITC_MEM_AW    9
`define ITC_MEM_WORDS 512
`define ITC_VEC_BASE  32'h0000_0400
`define ITC_WORD_STEP 32'h0000_0004
`define ITC_SRC_OFS   32'h0000_0008
`define ITC_DST_OFS   32'h0000_000C
`define ITC_ENT_STEP  32'h0000_0010
`define ITC_MF_SM     15:14
`define ITC_MF_DM     13:12
`define ITC_MF_MD     11:10
`define ITC_MF_SZ     9:8
`define ITC_MB_DTS    7
`define ITC_MB_CHN    6
`define ITC_MB_ISEL   5
`define ITC_MD_REPEAT 2'h1
`define ITC_MD_BLOCK  2'h2
`define ITC_AM_INC    2'h2
`define ITC_AM_DEC    2'h3
`define ITC_SZ_BYTE   2'h0
`define ITC_SZ_HALF   2'h1
`define ITC_SZ_LONG   2'h2
`define ITC_A_CHEN    12'h000
`define ITC_A_SWCTL   12'h004
`define ITC_A_BASE    12'h008
`define ITC_A_PEND    12'h00C
`define ITC_A_MEMWIN  12
`define ITC_SW_TRIG   8
`define ITC_RG_MOD2   4'hE
`define ITC_RG_MOD3   4'hF
`define ITC_ST_RAM    3'h1
`define ITC_ST_MOD2   3'h2
`define ITC_ST_MOD3   3'h3
`endif

//--- verilog/itc_pkg.sv
// Types and small helpers of the transfer controller pair.
// Assumes itc_consts.svh for widths and codes.
`include "itc_consts.svh"
package itc_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_VEC = 8'h02, ST_INFO = 8'h04, ST_DRD = 8'h08,
    ST_DWR  = 8'h10, ST_IOP = 8'h20, ST_WB   = 8'h40, ST_DONE = 8'h80
  } itc_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } itc_bus_t;

  typedef struct packed {
    itc_state_t  st;
    itc_bus_t    bus;
    logic        sw;
    logic [7:0]  idx;
    logic [31:0] info;
    logic [1:0]  wcnt;
    logic [15:0] mode;
    logic [15:0] cnt;
    logic [31:0] w1;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] src0;
    logic [31:0] dst0;
    logic [16:0] blk;
    logic        irq;
    logic        sw_served;
  } itc_dev_t;

  typedef struct packed {
    logic [`ITC_NSRC-1:0]             chen;
    logic [`ITC_NSRC-1:0]             pend;
    logic                             sw_trig;
    logic [7:0]                       sw_vec;
    logic [15:0]                      base;
    logic [31:0]                      prdata;
    logic [`ITC_MEM_WORDS-1:0][31:0]  mem;
  } itc_sys_t;

  typedef struct packed {
    logic [2:0] cnt;
  } itc_wait_t;

  function automatic itc_bus_t itc_mk_bus(input logic we, input logic [1:0] sz,
                                          input logic [31:0] a, input logic [31:0] d);
    itc_bus_t b;
    b.req   = 1'b1;
    b.we    = we;
    b.size  = sz;
    b.addr  = a;
    b.wdata = d;
    return b;
  endfunction

  function automatic logic [31:0] itc_size_mask(input logic [1:0] sz);
    if (sz == `ITC_SZ_BYTE) return 32'h0000_00FF;
    if (sz == `ITC_SZ_HALF) return 32'h0000_FFFF;
    return 32'hFFFF_FFFF;
  endfunction
endpackage

//--- verilog/itc_if.sv
// Link between the transfer controller and its system end.
// Assumes both ends run on one clock; ack is combinational.
`timescale 1ns/1ps
`include "itc_consts.svh"
interface itc_if;
  logic                 req;
  logic                 we;
  logic [1:0]           size;
  logic [31:0]          addr;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic                 ack;
  logic [`ITC_NSRC-1:0] src_req;
  logic [`ITC_NSRC-1:0] chen;
  logic                 sw_trig;
  logic [7:0]           sw_vec;
  logic [15:0]          base;
  logic                 src_clr;
  logic                 en_clr;
  logic                 sw_clr;
  logic [7:0]           clr_idx;

  modport dev (output req, we, size, addr, wdata, src_clr, en_clr, sw_clr, clr_idx,
               input rdata, ack, src_req, chen, sw_trig, sw_vec, base);
  modport sys (input req, we, size, addr, wdata, src_clr, en_clr, sw_clr, clr_idx,
               output rdata, ack, src_req, chen, sw_trig, sw_vec, base);
endinterface

//--- verilog/itc_wait_gen.sv
// Access state counter: answers a held request after its region's state count.
// Assumes the request and address stay stable until done.
`timescale 1ns/1ps
`include "itc_consts.svh"
module itc_wait_gen
  import itc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        REQ,
  input  wire logic [31:0] ADDR,
  input  wire logic [1:0]  SIZE,
  output logic             DONE
);
  itc_wait_t r;
  itc_wait_t n;
  logic [2:0] need;

  always_comb begin
    need = `ITC_ST_RAM;
    if (ADDR[31:28] == `ITC_RG_MOD2) need = `ITC_ST_MOD2;
    if (ADDR[31:28] == `ITC_RG_MOD3) need = `ITC_ST_MOD3;
    // Longwords take two module accesses; RAM stays single state
    if (SIZE == `ITC_SZ_LONG && need != `ITC_ST_RAM) need = need << 1;
    DONE = REQ && (r.cnt == need - `ITC_ST_RAM);
    n = r;
    n.cnt = (REQ && !DONE) ? r.cnt + 3'h1 : 3'h0;
  end

  always_ff @(posedge CLK) begin
    if (SRST) r <= '0;
    else r <= n;
  end
endmodule

//--- verilog/itc_sys_end.sv
// System end: channel enables, source flags, soft trigger, info base and memory.
// Assumes an APB master with zero wait states; sources pulse SRC_EVENT.
`timescale 1ns/1ps
`include "itc_consts.svh"
module itc_sys_end
  import itc_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  itc_if.sys                        LINK,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [15:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [`ITC_NSRC-1:0] SRC_EVENT
);
  itc_sys_t r;
  itc_sys_t n;
  logic [`ITC_MEM_AW-1:0] dev_idx;
  logic [`ITC_MEM_AW-1:0] apb_idx;
  logic [4:0]             dev_sh;
  logic                   memsel;

  function automatic logic reg_hit(input logic [11:0] off);
    return off == `ITC_A_CHEN || off == `ITC_A_SWCTL || off == `ITC_A_BASE || off == `ITC_A_PEND;
  endfunction

  itc_wait_gen u_wait (
    .CLK  (CLK),
    .SRST (SRST),
    .REQ  (LINK.req),
    .ADDR (LINK.addr),
    .SIZE (LINK.size),
    .DONE (LINK.ack)
  );

  assign dev_idx      = LINK.addr[`ITC_MEM_AW+1:2];
  assign apb_idx      = PADDR[`ITC_MEM_AW+1:2];
  assign dev_sh       = {LINK.addr[1:0], 3'h0};
  assign memsel       = PADDR[`ITC_A_MEMWIN];
  assign LINK.rdata   = (r.mem[dev_idx] >> dev_sh) & itc_size_mask(LINK.size);
  assign LINK.src_req = r.pend;
  assign LINK.chen    = r.chen;
  assign LINK.sw_trig = r.sw_trig;
  assign LINK.sw_vec  = r.sw_vec;
  assign LINK.base    = r.base;
  assign PRDATA       = r.prdata;
  assign PREADY       = 1'b1;
  assign PSLVERR      = PSEL && PENABLE && !memsel && !reg_hit(PADDR[11:0]);

  always_comb begin
    logic [`ITC_NSRC-1:0] clr;
    logic                 wr;
    logic                 rd;
    logic [31:0]          m;
    n   = r;
    clr = '0;
    wr  = PSEL && PENABLE && PWRITE;
    rd  = PSEL && !PENABLE && !PWRITE;
    m   = itc_size_mask(LINK.size) << dev_sh;
    if (LINK.src_clr) clr[LINK.clr_idx[4:0]] = 1'b1;
    if (wr && !memsel && PADDR[11:0] == `ITC_A_PEND) clr = clr | PWDATA;
    // A new event in the clearing cycle survives
    n.pend = (r.pend & ~clr) | SRC_EVENT;
    if (LINK.en_clr) n.chen[LINK.clr_idx[4:0]] = 1'b0;
    if (LINK.sw_clr) n.sw_trig = 1'b0;
    if (LINK.ack && LINK.we) begin
      n.mem[dev_idx] = (r.mem[dev_idx] & ~m) | ((LINK.wdata << dev_sh) & m);
    end
    if (wr && memsel) n.mem[apb_idx] = PWDATA;
    if (wr && !memsel) begin
      unique case (PADDR[11:0])
        `ITC_A_CHEN:  n.chen = PWDATA;
        `ITC_A_SWCTL: begin
          n.sw_trig = PWDATA[`ITC_SW_TRIG];
          n.sw_vec  = PWDATA[7:0];
        end
        `ITC_A_BASE:  n.base = PWDATA[15:0];
        default: ;
      endcase
    end
    if (rd) begin
      n.prdata = 32'h0000_0000;
      if (memsel) n.prdata = r.mem[apb_idx];
      else if (PADDR[11:0] == `ITC_A_CHEN) n.prdata = r.chen;
      else if (PADDR[11:0] == `ITC_A_SWCTL) n.prdata = {23'h0, r.sw_trig, r.sw_vec};
      else if (PADDR[11:0] == `ITC_A_BASE) n.prdata = {16'h0, r.base};
      else if (PADDR[11:0] == `ITC_A_PEND) n.prdata = r.pend;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) r <= '0;
    else r <= n;
  end
endmodule

//--- verilog/itc_dev_end.sv
// Transfer controller end: vector fetch, info read, data moves, write-back.
// Assumes a system end on itc_if that answers each held request with ack.
// Overview of operation
// - Repeat count per cycle is 1 to 256
// - Repeat wrap restores repeat area, keeps going
// - Repeat with select 0 never interrupts
// - Repeat write-back: keep reload, step low byte
// - Repeat wrap reloads area address, other steps
// - Block mode: one block per activation
// - After block, area address back to initial
// - Block mode interrupts when count one completes
// - Block write-back: count minus one, length untouched
// - Info read four cycles, write-back three
// - Vector, info, data pairs, one internal op
// - Module accesses cost two or three states, four or six for longwords
// - Total states sum; chaining adds transfers
// - Pending source with enable set starts transfer
// - Clear source or enable depending on interrupt
// - Software sets enable, clears source, re-enables
// - Software places info, base and vector first
// - Software checks trigger bit is zero first
// - Trigger bit plus vector byte starts activation
// - Trigger bit cleared unless interrupt requested
// - Soft vector fetched at base plus number
// - Repeat info: mode, count, initial, source, dest
// - Block info: mode, count, unused, length, addresses
`timescale 1ns/1ps
`include "itc_consts.svh"
module itc_dev_end
  import itc_pkg::*;
(
  input  wire logic CLK,
  input  wire logic SRST,
  itc_if.dev        LINK,
  output logic      BUSY,
  output logic      CPU_IRQ,
  output logic      CPU_IRQ_SW,
  output logic [7:0] CPU_IRQ_IDX
);
  localparam itc_dev_t DEV_RST = '{st: ST_IDLE, default: '0};

  itc_dev_t r;
  itc_dev_t n;
  logic     done;

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am,
                                            input logic [1:0] sz);
    logic [31:0] d;
    d = 32'h0000_0001 << sz;
    if (am == `ITC_AM_INC) return a + d;
    if (am == `ITC_AM_DEC) return a - d;
    return a;
  endfunction

  assign done         = (r.st == ST_DONE);
  assign LINK.req     = r.bus.req;
  assign LINK.we      = r.bus.we;
  assign LINK.size    = r.bus.size;
  assign LINK.addr    = r.bus.addr;
  assign LINK.wdata   = r.bus.wdata;
  assign LINK.clr_idx = r.idx;
  // Flags settle at the edge leaving DONE, so IDLE never sees a stale request
  assign LINK.src_clr = done && !r.sw && !r.irq;
  assign LINK.en_clr  = done && !r.sw && r.irq;
  assign LINK.sw_clr  = done && r.sw && !r.irq;
  assign CPU_IRQ      = done && r.irq;
  assign CPU_IRQ_SW   = done && r.sw && r.irq;
  assign CPU_IRQ_IDX  = r.idx;
  assign BUSY         = (r.st != ST_IDLE);

  always_comb begin
    logic        hit;
    logic [7:0]  hidx;
    logic [1:0]  sz;
    logic [31:0] nsrc;
    logic [31:0] ndst;
    logic [15:0] ncnt;
    logic        wrap;
    logic        irq_now;
    n       = r;
    hit     = 1'b0;
    hidx    = 8'h00;
    sz      = r.mode[`ITC_MF_SZ];
    nsrc    = step_addr(r.src, r.mode[`ITC_MF_SM], sz);
    ndst    = step_addr(r.dst, r.mode[`ITC_MF_DM], sz);
    ncnt    = r.cnt;
    wrap    = 1'b0;
    irq_now = 1'b0;
    // Lowest index wins among enabled pending sources
    for (int i = `ITC_NSRC - 1; i >= 0; i--) begin
      if (LINK.src_req[i] && LINK.chen[i]) begin
        hit  = 1'b1;
        hidx = 8'(i);
      end
    end
    unique case (r.st)
      ST_IDLE: begin
        if (!LINK.sw_trig) n.sw_served = 1'b0;
        n.irq = 1'b0;
        if (hit) begin
          n.sw  = 1'b0;
          n.idx = hidx;
          n.bus = itc_mk_bus(1'b0, `ITC_SZ_HALF, `ITC_VEC_BASE + {23'h0, hidx, 1'b0}, '0);
          n.st  = ST_VEC;
        end else if (LINK.sw_trig && !r.sw_served) begin
          n.sw  = 1'b1;
          n.idx = LINK.sw_vec;
          n.bus = itc_mk_bus(1'b0, `ITC_SZ_HALF, `ITC_VEC_BASE + {24'h0, LINK.sw_vec}, '0);
          n.st  = ST_VEC;
        end
      end
      ST_VEC: begin
        if (LINK.ack) begin
          n.info = {LINK.base, LINK.rdata[15:0]};
          n.wcnt = 2'h0;
          n.bus  = itc_mk_bus(1'b0, `ITC_SZ_LONG, {LINK.base, LINK.rdata[15:0]}, '0);
          n.st   = ST_INFO;
        end
      end
      ST_INFO: begin
        if (LINK.ack) begin
          // Word 1 is initial address in repeat, length in block
          unique case (r.wcnt)
            2'h0: begin
              n.mode = LINK.rdata[31:16];
              n.cnt  = LINK.rdata[15:0];
            end
            2'h1: n.w1 = LINK.rdata;
            2'h2: begin
              n.src  = LINK.rdata;
              n.src0 = LINK.rdata;
            end
            2'h3: begin
              n.dst  = LINK.rdata;
              n.dst0 = LINK.rdata;
            end
          endcase
          if (r.wcnt == 2'h3) begin
            n.blk = 17'h0_0001;
            if (r.mode[`ITC_MF_MD] == `ITC_MD_BLOCK) begin
              n.blk = (r.w1[15:0] == 16'h0000) ? 17'h1_0000 : {1'b0, r.w1[15:0]};
            end
            n.bus = itc_mk_bus(1'b0, sz, r.src, '0);
            n.st  = ST_DRD;
          end else begin
            n.wcnt = r.wcnt + 2'h1;
            n.bus  = itc_mk_bus(1'b0, `ITC_SZ_LONG, r.bus.addr + `ITC_WORD_STEP, '0);
          end
        end
      end
      ST_DRD: begin
        if (LINK.ack) begin
          n.bus = itc_mk_bus(1'b1, sz, r.dst, LINK.rdata);
          n.st  = ST_DWR;
        end
      end
      ST_DWR: begin
        if (LINK.ack) begin
          n.src = nsrc;
          n.dst = ndst;
          n.blk = r.blk - 17'h0_0001;
          if (r.blk != 17'h0_0001) begin
            n.bus = itc_mk_bus(1'b0, sz, nsrc, '0);
            n.st  = ST_DRD;
          end else begin
            n.bus = '0;
            n.st  = ST_IOP;
          end
        end
      end
      ST_IOP: begin
        // Single internal-operation cycle settles the write-back image
        if (r.mode[`ITC_MF_MD] == `ITC_MD_REPEAT) begin
          wrap    = (r.cnt[7:0] == 8'h01);
          ncnt    = {r.cnt[15:8], wrap ? r.cnt[15:8] : r.cnt[7:0] - 8'h01};
          irq_now = r.mode[`ITC_MB_ISEL];
          if (wrap && r.mode[`ITC_MB_DTS]) n.src = r.w1;
          if (wrap && !r.mode[`ITC_MB_DTS]) n.dst = r.w1;
        end else begin
          ncnt    = r.cnt - 16'h0001;
          irq_now = r.mode[`ITC_MB_ISEL] || (r.cnt == 16'h0001);
          if (r.mode[`ITC_MF_MD] == `ITC_MD_BLOCK) begin
            if (r.mode[`ITC_MB_DTS]) n.src = r.src0;
            else n.dst = r.dst0;
          end
        end
        n.cnt  = ncnt;
        n.irq  = r.irq || irq_now;
        n.wcnt = 2'h0;
        n.bus  = itc_mk_bus(1'b1, `ITC_SZ_LONG, r.info, {r.mode, ncnt});
        n.st   = ST_WB;
      end
      ST_WB: begin
        if (LINK.ack) begin
          // Word 1 is skipped: initial address and length stay as loaded
          n.wcnt = r.wcnt + 2'h1;
          if (r.wcnt == 2'h0) begin
            n.bus = itc_mk_bus(1'b1, `ITC_SZ_LONG, r.info + `ITC_SRC_OFS, r.src);
          end else if (r.wcnt == 2'h1) begin
            n.bus = itc_mk_bus(1'b1, `ITC_SZ_LONG, r.info + `ITC_DST_OFS, r.dst);
          end else if (r.mode[`ITC_MB_CHN]) begin
            n.info = r.info + `ITC_ENT_STEP;
            n.wcnt = 2'h0;
            n.bus  = itc_mk_bus(1'b0, `ITC_SZ_LONG, r.info + `ITC_ENT_STEP, '0);
            n.st   = ST_INFO;
          end else begin
            n.bus = '0;
            n.st  = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Trigger left at one must not restart until software drops it
        if (r.sw && r.irq) n.sw_served = 1'b1;
        n.st = ST_IDLE;
      end
      default: n = DEV_RST;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) r <= DEV_RST;
    else r <= n;
  end
endmodule

//--- verif/itc_sva.sv
// Checker for the controller link: request timing, activation shape and end flags.
// Assumes info entries in one-state RAM, no chaining; signals come from the link.
`timescale 1ns/1ps
`include "itc_consts.svh"
module itc_sva
  import itc_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 SRST,
  input wire logic                 req,
  input wire logic                 we,
  input wire logic [1:0]           size,
  input wire logic [31:0]          addr,
  input wire logic [31:0]          wdata,
  input wire logic                 ack,
  input wire logic [`ITC_NSRC-1:0] src_req,
  input wire logic [`ITC_NSRC-1:0] chen,
  input wire logic                 sw_trig,
  input wire logic [15:0]          base,
  input wire logic                 src_clr,
  input wire logic                 en_clr,
  input wire logic                 sw_clr,
  input wire logic [7:0]           clr_idx,
  input wire logic                 BUSY,
  input wire logic                 CPU_IRQ,
  input wire logic                 CPU_IRQ_SW,
  input wire logic [7:0]           CPU_IRQ_IDX
);
  logic [2:0] wc_reg;
  logic [2:0] wc_next;
  logic [2:0] st_need;
  logic       fin;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Waited states of the request in flight
  always_comb begin
    wc_next = (req && !ack) ? wc_reg + 3'h1 : 3'h0;
    st_need = 3'h1;
    if (addr[31:28] == `ITC_RG_MOD2) st_need = (size == `ITC_SZ_LONG) ? 3'h4 : 3'h2;
    if (addr[31:28] == `ITC_RG_MOD3) st_need = (size == `ITC_SZ_LONG) ? 3'h6 : 3'h3;
    fin = src_clr || en_clr || sw_clr;
  end
  always_ff @(posedge CLK) begin
    wc_reg <= SRST ? 3'h0 : wc_next;
  end

  property p_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(size) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_states;
    req && ack |-> wc_reg == st_need - 3'h1;
  endproperty
  a_states: assert property (p_states) else $error("access state count wrong");
  property p_nocap;
    req |-> wc_reg < st_need;
  endproperty
  a_nocap: assert property (p_nocap) else $error("access overran its states");
  property p_vec;
    $rose(BUSY) |-> req && !we && size == `ITC_SZ_HALF && addr[31:9] == 23'h00_0002;
  endproperty
  a_vec: assert property (p_vec) else $error("activation did not open with vector read");
  property p_info;
    $rose(BUSY) && base[15:12] < `ITC_RG_MOD2 |=> (req && !we && ack)[*4];
  endproperty
  a_info: assert property (p_info) else $error("info read not four cycles");
  property p_wb;
    fin |-> $past(we && ack, 1) && $past(we && ack, 2) && $past(we && ack, 3) && !$past(req, 4);
  endproperty
  a_wb: assert property (p_wb) else $error("write-back not three cycles after internal op");
  property p_irq;
    CPU_IRQ && !CPU_IRQ_SW |-> en_clr && !src_clr && clr_idx == CPU_IRQ_IDX;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt job did not clear enable only");
  property p_swirq;
    fin |-> $onehot0({src_clr, en_clr, sw_clr}) && !(CPU_IRQ && CPU_IRQ_SW) && !(sw_clr && !sw_trig);
  endproperty
  a_swirq: assert property (p_swirq) else $error("end flags inconsistent");
  property p_start;
    !BUSY && (src_req & chen) != '0 |=> BUSY;
  endproperty
  a_start: assert property (p_start) else $error("enabled pending source not started");
  property p_idle;
    fin |=> !BUSY;
  endproperty
  a_idle: assert property (p_idle) else $error("busy after write-back");

  c_irq: cover property (CPU_IRQ && !CPU_IRQ_SW);
  c_swirq: cover property (CPU_IRQ && CPU_IRQ_SW);
  c_swclr: cover property (sw_clr);
  c_slow: cover property (req && ack && wc_reg == 3'h5);
endmodule

//--- verif/testbench.sv
// Self-checking bench: both controller ends on one link, driven over APB and source pulses.
// Assumes info entries in low RAM with info base 0; addresses wrap in the 2 KB memory.
`timescale 1ns/1ps
`include "itc_consts.svh"
module testbench
  import itc_pkg::*;
;
  logic                 clk, srst, psel, penable, pwrite, pready, pslverr, err, busy;
  logic                 cpu_irq, cpu_irq_sw, irq_sw;
  logic [15:0]          paddr, m;
  logic [31:0]          pwdata, prdata, rd;
  logic [31:0]          ws[4];
  logic [`ITC_NSRC-1:0] src_event;
  logic [7:0]           cpu_irq_idx, irq_idx, hi;
  int                   num_errors, check_count, irq_cnt, len;

  itc_if itc_if_inst();
  itc_sys_end itc_sys_end_inst(.CLK(clk), .SRST(srst), .LINK(itc_if_inst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SRC_EVENT(src_event));
  itc_dev_end itc_dev_end_inst(.CLK(clk), .SRST(srst), .LINK(itc_if_inst), .BUSY(busy), .CPU_IRQ(cpu_irq),
    .CPU_IRQ_SW(cpu_irq_sw), .CPU_IRQ_IDX(cpu_irq_idx));
  itc_sva itc_sva_inst(.CLK(clk), .SRST(srst), .req(itc_if_inst.req), .we(itc_if_inst.we),
    .size(itc_if_inst.size), .addr(itc_if_inst.addr), .wdata(itc_if_inst.wdata), .ack(itc_if_inst.ack),
    .src_req(itc_if_inst.src_req), .chen(itc_if_inst.chen), .sw_trig(itc_if_inst.sw_trig),
    .base(itc_if_inst.base), .src_clr(itc_if_inst.src_clr), .en_clr(itc_if_inst.en_clr),
    .sw_clr(itc_if_inst.sw_clr), .clr_idx(itc_if_inst.clr_idx), .BUSY(busy), .CPU_IRQ(cpu_irq),
    .CPU_IRQ_SW(cpu_irq_sw), .CPU_IRQ_IDX(cpu_irq_idx));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cpu_irq === 1'b1) begin
      irq_cnt++;
      irq_idx = cpu_irq_idx;
      irq_sw = cpu_irq_sw;
    end
  end

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One idle cycle after each transfer keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic mw(input logic [10:0] a, input logic [31:0] d);
    apb(1'b1, 16'h1000 | {5'h00, a}, d);
  endtask

  task automatic mchk(input string nm, input logic [10:0] a, input logic [31:0] e);
    apb(1'b0, 16'h1000 | {5'h00, a}, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic wait_job;
    @(posedge clk);
    while (busy !== 1'b1) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  task automatic fire(input int i);
    src_event[i] <= 1'b1;
    @(posedge clk);
    src_event <= '0;
    wait_job;
  endtask

  function automatic logic [15:0] md(input logic [1:0] sm, input logic [1:0] dm, input logic [1:0] mo,
                                     input logic area_select_bit, input logic isel);
    return {sm, dm, mo, `ITC_SZ_LONG, area_select_bit, 1'b0, isel, 5'h00};
  endfunction

  function automatic logic [15:0] rep_cnt(input logic [15:0] c);
    return (c[7:0] == 8'h01) ? {c[15:8], c[15:8]} : c - 16'h0001;
  endfunction

  initial begin
    #100_000;  // Whole run needs a few hundred cycles at most
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    close_out;
  end

  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, src_event} = '0;
    srst = 1'b1;
    void'($urandom(74957));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // Repeat job on source 0: step, then wrap of the source area
    hi = 8'($urandom_range(2, 255));
    for (int k = 0; k < 4; k++) begin
      ws[k] = $urandom;
      mw(11'h200 + 11'(4 * k), ws[k]);
    end
    m = md(`ITC_AM_INC, 2'h0, `ITC_MD_REPEAT, 1'b1, 1'b0);
    mw(11'h400, 32'h0110_0100);
    mw(11'h100, {m, hi, 8'h02});
    mw(11'h104, 32'h0000_0200);
    mw(11'h108, 32'h0000_0204);
    mw(11'h10C, 32'hF000_0300);
    apb(1'b1, 16'(`ITC_A_CHEN), 32'h0000_0003);
    fire(0);
    mchk("rep data", 11'h300, ws[1]);
    mchk("rep count", 11'h100, {m, rep_cnt({hi, 8'h02})});
    mchk("rep src", 11'h108, 32'h0000_0208);
    fire(0);
    mchk("rep data", 11'h300, ws[2]);
    mchk("rep count", 11'h100, {m, rep_cnt({hi, 8'h01})});
    mchk("rep src", 11'h108, 32'h0000_0200);
    mchk("rep dst", 11'h10C, 32'hF000_0300);
    mchk("rep init", 11'h104, 32'h0000_0200);
    chk("irq count", 32'h0000_0000, 32'(irq_cnt));
    apb(1'b0, 16'(`ITC_A_CHEN), 32'h0000_0000);
    chk("enables", 32'h0000_0003, rd);
    apb(1'b0, 16'(`ITC_A_PEND), 32'h0000_0000);
    chk("pending", 32'h0000_0000, rd);
    $display("test repeat done");
    // Block job on source 1, last count, module-region source
    len = $urandom_range(1, 4);
    for (int k = 0; k < len; k++) begin
      ws[k] = $urandom;
      mw(11'h240 + 11'(4 * k), ws[k]);
    end
    m = md(`ITC_AM_INC, `ITC_AM_INC, `ITC_MD_BLOCK, 1'b0, 1'b0);
    mw(11'h110, {m, 16'h0001});
    mw(11'h114, 32'(len));
    mw(11'h118, 32'hE000_0240);
    mw(11'h11C, 32'h0000_0380);
    fire(1);
    for (int k = 0; k < len; k++) mchk("blk data", 11'h380 + 11'(4 * k), ws[k]);
    mchk("blk count", 11'h110, {m, 16'h0000});
    mchk("blk length", 11'h114, 32'(len));
    mchk("blk src", 11'h118, 32'hE000_0240 + 32'(4 * len));
    mchk("blk dst", 11'h11C, 32'h0000_0380);
    chk("irq count", 32'h0000_0001, 32'(irq_cnt));
    chk("irq index", 32'h0000_0001, {24'h00_0000, irq_idx});
    apb(1'b0, 16'(`ITC_A_CHEN), 32'h0000_0000);
    chk("enables", 32'h0000_0001, rd);
    apb(1'b0, 16'(`ITC_A_PEND), 32'h0000_0000);
    chk("pending", 32'h0000_0002, rd);
    apb(1'b1, 16'(`ITC_A_PEND), 32'h0000_0002);
    $display("test block done");
    // Software jobs: without and with interrupt
    m = md(2'h0, `ITC_AM_DEC, `ITC_MD_REPEAT, 1'b1, 1'b0);
    mw(11'h440, 32'h0000_0120);
    mw(11'h120, {m, hi, 8'h03});
    mw(11'h124, 32'h0000_0200);
    mw(11'h128, 32'h0000_0200);
    mw(11'h12C, 32'h0000_03C0);
    apb(1'b0, 16'(`ITC_A_SWCTL), 32'h0000_0000);
    chk("trigger idle", 32'h0000_0000, {23'h0, rd[8], 8'h00});
    apb(1'b1, 16'(`ITC_A_SWCTL), 32'h0000_0140);
    wait_job;
    mchk("sw dst", 11'h12C, 32'h0000_03BC);
    mchk("sw count", 11'h120, {m, rep_cnt({hi, 8'h03})});
    apb(1'b0, 16'(`ITC_A_SWCTL), 32'h0000_0000);
    chk("sw ctrl", 32'h0000_0040, rd);
    // Chained normal-mode entry behind the interrupting repeat entry
    m = md(`ITC_AM_INC, 2'h0, 2'h0, 1'b0, 1'b0);
    mw(11'h130, {m, 16'h0002});
    mw(11'h138, 32'h0000_0380);
    mw(11'h13C, 32'h0000_03E0);
    m = md(2'h0, `ITC_AM_INC, `ITC_MD_REPEAT, 1'b1, 1'b1);
    mw(11'h120, {m | 16'h0040, hi, 8'h02});
    apb(1'b1, 16'(`ITC_A_SWCTL), 32'h0000_0140);
    wait_job;
    chk("irq count", 32'h0000_0002, 32'(irq_cnt));
    chk("irq soft", 32'h0000_0140, {23'h0, irq_sw, irq_idx});
    mchk("chain data", 11'h3E0, ws[0]);
    mchk("chain src", 11'h138, 32'h0000_0384);
    apb(1'b0, 16'(`ITC_A_SWCTL), 32'h0000_0000);
    chk("sw ctrl", 32'h0000_0140, rd);
    apb(1'b1, 16'(`ITC_A_SWCTL), 32'h0000_0000);
    $display("test software done");
    // Unmapped register offset
    apb(1'b0, 16'h0010, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    $display("test unmapped done");
    close_out;
  end
endmodule
